// >>> ewp_defines.vh
`ifndef EWP_DEFINES_VH
`define EWP_DEFINES_VH
// Register byte offsets.
`define EWP_REG_CTRL      12'h000
`define EWP_REG_ADDR      12'h004
`define EWP_REG_WDATA     12'h008
`define EWP_REG_STATUS    12'h00C
`define EWP_REG_RDATA     12'h010
// Control register fields (write one to start).
`define EWP_CTRL_WRITE_PULSE_PIN     0
`define EWP_CTRL_READ     1
// Status register fields.
`define EWP_ST_BUSY       0
`define EWP_ST_DONE       1
`define EWP_ST_OK         2
`define EWP_ST_RANGE_N    3
`define EWP_ST_INSERT     4
`define EWP_ST_NOHV       5
`define EWP_ST_VERIFY     6
`define EWP_ST_RDEN       7
// Reset values.
`define EWP_ADDR_RST      12'h000
`define EWP_WDATA_RST     8'h00
// Timing figures and derived cycle counts at 100 MHz.
`define EWP_CLK_MHZ       100
`define EWP_PULSE_MS      50
`define EWP_PULSE_CYC     (`EWP_PULSE_MS * 1000 * `EWP_CLK_MHZ)
`define EWP_STEP_US       10
`define EWP_STEP_CYC      (`EWP_STEP_US * `EWP_CLK_MHZ)
`define EWP_XTAL_KHZ      5185
`define EWP_XTAL_HALF     ((`EWP_CLK_MHZ * 1000) / (2 * `EWP_XTAL_KHZ))
`define EWP_FETCH_COUNT   1024
`endif

// >>> ewp_fetch_counter.v
`timescale 1ns/100ps
`default_nettype none
module ewp_fetch_counter #(
    parameter integer COUNT = 1024,
    parameter integer WIDTH = 11
) (
    input  wire clock_i,
    input  wire rst_n_i,
    input  wire clear_i,
    input  wire strobe_i,
    output reg  full_o
);
    reg  [WIDTH-1:0] count_ff;
    reg              strobe_d_ff;
    wire             rise = strobe_i & ~strobe_d_ff;

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_ff    <= {WIDTH{1'b0}};
            strobe_d_ff <= 1'b0;
            full_o      <= 1'b0;
        end else begin
            strobe_d_ff <= strobe_i;
            if (clear_i) begin
                count_ff <= {WIDTH{1'b0}};
                full_o   <= 1'b0;
            end else if (rise && !full_o) begin
                count_ff <= count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
                if (count_ff == COUNT[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    full_o <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> ewp_programmer.v
// Functional notes
// - Erased word reads zero; program ones.
// - Program all eight bits together.
// - Present address after reset and mode raise.
// - Reset pulse latches address, then data.
// - Program with supply, mode, pulse high.
// - Address select low routes address bits.
// - Address select high routes write word.
// - Direction low to accept, high reading.
// - Invert target byte, drive when enabled.
// - Range fault when upper address bits set.
// - Reset target, clear counter, count fetches.
// - Counter low means insertion fault.
// - Mode drive low raises mode line.
// - Boost raises supply; fall control lowers.
// - Pulse pin floats, grounds, then driven.
// - Program pulse lasts about 50 ms.
// - Continuous crystal reference to target.
// - Separate program and read entries.
// - Faults abort after reset and fetch scan, before mode raise.
// - Return word and success status.
// - No high voltage aborts programming.
// - Verify; retry once; then error.
`timescale 1ns/100ps
`default_nettype none
`include "ewp_defines.vh"
module ewp_programmer #(
    parameter integer PULSE_CYC = `EWP_PULSE_CYC,
    parameter integer STEP_CYC  = `EWP_STEP_CYC,
    parameter integer SCAN_CYC  = 40000,
    parameter integer FETCHES   = `EWP_FETCH_COUNT
) (
    input  wire        clock_i,
    input  wire        rst_n_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    input  wire [7:0]  target_bus_lines_i,
    output reg  [7:0]  target_bus_lines_o,
    output reg         target_bus_lines_oe_o,
    output reg  [1:0]  port_two_low_pins_o,
    input  wire        fetch_strobe_i,
    input  wire        high_voltage_ok_i,
    output reg         target_reset_pulse_o,
    output reg         direction_ctl_out_o,
    output reg         high_addr_drive_n_o,
    output reg         supply_boost_n_o,
    output reg         supply_fall_ctl_n_o,
    output reg         pulse_drive_n_o,
    output reg         write_pulse_ground_o,
    output reg         crystal_input_pin_o,
    output reg  [7:0]  read_word_o
);
    localparam [12:0] S_IDLE  = 13'h0001;
    localparam [12:0] S_RST   = 13'h0002;
    localparam [12:0] S_SCAN  = 13'h0004;
    localparam [12:0] S_CHECK = 13'h0008;
    localparam [12:0] S_MODE  = 13'h0010;
    localparam [12:0] S_ADDR  = 13'h0020;
    localparam [12:0] S_LATCH = 13'h0040;
    localparam [12:0] S_DATA  = 13'h0080;
    localparam [12:0] S_BOOST = 13'h0100;
    localparam [12:0] S_PULSE = 13'h0200;
    localparam [12:0] S_FALL  = 13'h0400;
    localparam [12:0] S_READ  = 13'h0800;
    localparam [12:0] S_DONE  = 13'h1000;

    reg  [12:0] state_ff;
    reg  [12:0] nxt_state;
    reg  [31:0] timer_ff;
    reg  [31:0] nxt_timer;
    reg  [11:0] addr_ff;
    reg  [7:0]  wdata_ff;
    reg         op_write_pulse_pin_ff;
    reg         retry_ff;
    reg         nxt_retry;
    reg         busy_ff;
    reg         done_ff;
    reg         ok_ff;
    reg         nohv_ff;
    reg         verr_ff;
    reg         ins_err_ff;
    reg         rden_ff;
    reg         clr_cnt_ff;
    reg         addr_sel_n_ff;
    reg  [7:0]  xtal_cnt_ff;
    reg  [7:0]  captured_ff;
    wire        cnt_full;
    wire        range_n = ~(addr_ff[11] | addr_ff[10]);
    wire        timer_done = (timer_ff == 32'h0000_0000);
    wire        wr_go = psel_i & penable_i & pwrite_i & ~busy_ff;
    wire        start_write_pulse_pin = wr_go & (paddr_i == `EWP_REG_CTRL) & pwdata_i[`EWP_CTRL_WRITE_PULSE_PIN];
    wire        start_read = wr_go & (paddr_i == `EWP_REG_CTRL) & pwdata_i[`EWP_CTRL_READ]
                             & ~pwdata_i[`EWP_CTRL_WRITE_PULSE_PIN];
    wire [7:0]  status = {rden_ff, verr_ff, nohv_ff, ins_err_ff, range_n,
                          ok_ff, done_ff, busy_ff};
    // The target takes the address as its reset line rises, so it stays one cycle past the pulse.
    wire        addr_phase = (nxt_state == S_ADDR) || (nxt_state == S_LATCH) || (state_ff == S_LATCH);

    ewp_fetch_counter #(
        .COUNT (FETCHES),
        .WIDTH (11)
    ) u_fetch (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .clear_i  (clr_cnt_ff),
        .strobe_i (fetch_strobe_i),
        .full_o   (cnt_full)
    );

    // The supervisor may only change operands while idle, so a running sequence sees them stable.
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_ff   <= `EWP_ADDR_RST;
            wdata_ff  <= `EWP_WDATA_RST;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= psel_i & ~penable_i;
            pslverr_o <= 1'b0;
            if (wr_go && paddr_i == `EWP_REG_ADDR) begin
                addr_ff <= pwdata_i[11:0];
            end
            if (wr_go && paddr_i == `EWP_REG_WDATA) begin
                wdata_ff <= pwdata_i[7:0];
            end
            if (psel_i && !penable_i) begin
                case (paddr_i)
                    `EWP_REG_CTRL:   prdata_o <= 32'h0000_0000;
                    `EWP_REG_ADDR:   prdata_o <= {20'h00000, addr_ff};
                    `EWP_REG_WDATA:  prdata_o <= {24'h000000, wdata_ff};
                    `EWP_REG_STATUS: prdata_o <= {24'h000000, status};
                    `EWP_REG_RDATA:  prdata_o <= {24'h000000, read_word_o};
                    default: begin
                        prdata_o  <= 32'h0000_0000;
                        pslverr_o <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Free-running divider; the target needs its clock even between operations.
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xtal_cnt_ff         <= 8'h00;
            crystal_input_pin_o <= 1'b0;
        end else if (xtal_cnt_ff == `EWP_XTAL_HALF - 1) begin
            xtal_cnt_ff         <= 8'h00;
            crystal_input_pin_o <= ~crystal_input_pin_o;
        end else begin
            xtal_cnt_ff <= xtal_cnt_ff + 8'h01;
        end
    end

    always @* begin
        nxt_state = state_ff;
        nxt_timer = timer_done ? 32'h0000_0000 : timer_ff - 32'h0000_0001;
        nxt_retry = retry_ff;
        case (state_ff)
            S_IDLE: begin
                if (start_write_pulse_pin || start_read) begin
                    nxt_state = S_RST;
                    nxt_timer = STEP_CYC;
                    nxt_retry = 1'b0;
                end
            end
            S_RST: begin
                if (timer_done) begin
                    nxt_state = S_SCAN;
                    nxt_timer = SCAN_CYC;
                end
            end
            S_SCAN: begin
                if (timer_done || cnt_full) begin
                    nxt_state = S_CHECK;
                end
            end
            S_CHECK: begin
                if (!cnt_full || !range_n || (op_write_pulse_pin_ff && !high_voltage_ok_i)) begin
                    nxt_state = S_DONE;
                end else begin
                    nxt_state = S_MODE;
                    nxt_timer = STEP_CYC;
                end
            end
            S_MODE: begin
                if (timer_done) begin
                    nxt_state = S_ADDR;
                    nxt_timer = STEP_CYC;
                end
            end
            S_ADDR: begin
                if (timer_done) begin
                    nxt_state = S_LATCH;
                    nxt_timer = STEP_CYC;
                end
            end
            S_LATCH: begin
                if (timer_done) begin
                    nxt_state = op_write_pulse_pin_ff ? S_DATA : S_READ;
                    nxt_timer = STEP_CYC;
                end
            end
            S_DATA: begin
                if (timer_done) begin
                    nxt_state = S_BOOST;
                    nxt_timer = STEP_CYC;
                end
            end
            S_BOOST: begin
                if (timer_done) begin
                    nxt_state = S_PULSE;
                    nxt_timer = PULSE_CYC;
                end
            end
            S_PULSE: begin
                if (timer_done) begin
                    nxt_state = S_FALL;
                    nxt_timer = STEP_CYC;
                end
            end
            S_FALL: begin
                if (timer_done) begin
                    nxt_state = S_READ;
                    nxt_timer = STEP_CYC;
                end
            end
            S_READ: begin
                if (timer_done) begin
                    if (op_write_pulse_pin_ff && captured_ff != wdata_ff && !retry_ff) begin
                        nxt_state = S_LATCH;
                        nxt_timer = STEP_CYC;
                        nxt_retry = 1'b1;
                    end else begin
                        nxt_state = S_DONE;
                    end
                end
            end
            S_DONE: nxt_state = S_IDLE;
            default: nxt_state = S_IDLE;
        endcase
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff   <= S_IDLE;
            timer_ff   <= 32'h0000_0000;
            retry_ff   <= 1'b0;
            op_write_pulse_pin_ff <= 1'b0;
            busy_ff    <= 1'b0;
            done_ff    <= 1'b0;
            ok_ff      <= 1'b0;
            nohv_ff    <= 1'b0;
            verr_ff    <= 1'b0;
            ins_err_ff <= 1'b0;
            rden_ff    <= 1'b0;
            captured_ff <= 8'h00;
            read_word_o <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            timer_ff <= nxt_timer;
            retry_ff <= nxt_retry;
            if (state_ff == S_IDLE && (start_write_pulse_pin || start_read)) begin
                op_write_pulse_pin_ff <= start_write_pulse_pin;
                busy_ff    <= 1'b1;
                done_ff    <= 1'b0;
                ok_ff      <= 1'b0;
                nohv_ff    <= 1'b0;
                verr_ff    <= 1'b0;
                rden_ff    <= 1'b0;
            end
            if (state_ff == S_CHECK) begin
                ins_err_ff <= ~cnt_full;
                nohv_ff    <= op_write_pulse_pin_ff & ~high_voltage_ok_i;
            end
            if (state_ff == S_READ) begin
                captured_ff <= ~target_bus_lines_i;
            end
            if (state_ff == S_READ && timer_done) begin
                rden_ff     <= 1'b1;
                read_word_o <= captured_ff;
            end
            if (state_ff == S_DONE) begin
                busy_ff <= 1'b0;
                done_ff <= 1'b1;
                ok_ff   <= rden_ff & (~op_write_pulse_pin_ff | (captured_ff == wdata_ff));
                verr_ff <= rden_ff & op_write_pulse_pin_ff & (captured_ff != wdata_ff);
            end
        end
    end

    // Pin control is registered from the state so every pin comes straight off a flop.
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            target_reset_pulse_o  <= 1'b1;
            clr_cnt_ff            <= 1'b0;
            direction_ctl_out_o   <= 1'b1;
            high_addr_drive_n_o   <= 1'b1;
            supply_boost_n_o      <= 1'b1;
            supply_fall_ctl_n_o   <= 1'b1;
            pulse_drive_n_o       <= 1'b1;
            write_pulse_ground_o  <= 1'b0;
            addr_sel_n_ff         <= 1'b1;
            target_bus_lines_o    <= 8'h00;
            target_bus_lines_oe_o <= 1'b0;
            port_two_low_pins_o   <= 2'b00;
        end else begin
            target_reset_pulse_o <= ~(nxt_state == S_RST || nxt_state == S_LATCH);
            clr_cnt_ff           <= (nxt_state == S_RST);
            high_addr_drive_n_o  <= ~(nxt_state != S_IDLE && nxt_state != S_RST
                                      && nxt_state != S_SCAN && nxt_state != S_CHECK
                                      && nxt_state != S_DONE);
            // Direction goes low only for the programming write phase.
            direction_ctl_out_o  <= ~(op_write_pulse_pin_ff && !addr_phase && (nxt_state == S_DATA
                                      || nxt_state == S_BOOST || nxt_state == S_PULSE
                                      || nxt_state == S_FALL));
            addr_sel_n_ff        <= ~addr_phase;
            supply_boost_n_o     <= ~(nxt_state == S_BOOST || nxt_state == S_PULSE);
            supply_fall_ctl_n_o  <= ~(nxt_state == S_FALL);
            pulse_drive_n_o      <= ~(nxt_state == S_PULSE);
            write_pulse_ground_o <= op_write_pulse_pin_ff && nxt_state != S_IDLE
                                    && nxt_state != S_PULSE && nxt_state != S_DONE;
            target_bus_lines_oe_o <= addr_phase | ~(nxt_state == S_READ || nxt_state == S_IDLE
                                      || nxt_state == S_SCAN || nxt_state == S_RST
                                      || nxt_state == S_CHECK || nxt_state == S_DONE
                                      || nxt_state == S_MODE);
            if (addr_phase) begin
                target_bus_lines_o  <= addr_ff[7:0];
                port_two_low_pins_o <= addr_ff[9:8];
            end else begin
                target_bus_lines_o  <= wdata_ff;
            end
        end
    end
endmodule
`default_nettype wire

// >>> ewp_programmer_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "ewp_defines.vh"
module ewp_programmer_chk #(
    parameter integer PULSE_CYC = 50
) (
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    input wire logic [7:0]  target_bus_lines_o,
    input wire logic        target_bus_lines_oe_o,
    input wire logic [1:0]  port_two_low_pins_o,
    input wire logic        target_reset_pulse_o,
    input wire logic        direction_ctl_out_o,
    input wire logic        high_addr_drive_n_o,
    input wire logic        supply_boost_n_o,
    input wire logic        supply_fall_ctl_n_o,
    input wire logic        pulse_drive_n_o,
    input wire logic        write_pulse_ground_o,
    input wire logic        crystal_input_pin_o
);
    logic [11:0] addr_ff;
    logic [7:0]  wdata_ff;
    integer      pcnt_ff;
    integer      xcnt_ff;
    logic        xprev_ff;
    wire         wr_take = psel_i && penable_i && pwrite_i && pready_o;
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_ff <= 12'h000;
            wdata_ff <= 8'h00;
            pcnt_ff <= 0;
            xcnt_ff <= 0;
            xprev_ff <= 1'b0;
        end else begin
            if (wr_take && paddr_i == `EWP_REG_ADDR) addr_ff <= pwdata_i[11:0];
            if (wr_take && paddr_i == `EWP_REG_WDATA) wdata_ff <= pwdata_i[7:0];
            pcnt_ff <= pulse_drive_n_o ? 0 : pcnt_ff + 1;
            xprev_ff <= crystal_input_pin_o;
            xcnt_ff <= (crystal_input_pin_o != xprev_ff) ? 0 : xcnt_ff + 1;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_latch;
        $rose(target_reset_pulse_o) && !high_addr_drive_n_o;
    endsequence
    sequence s_pulse_end;
        $rose(pulse_drive_n_o);
    endsequence
    AST_PREADY: assert property (s_setup |=> pready_o ##1 !pready_o)
        else $error("pready not a single cycle after setup");
    AST_DIR: assert property (!direction_ctl_out_o |-> target_bus_lines_oe_o)
        else $error("target told to accept while bus undriven");
    AST_LATCH: assert property (s_latch |-> target_bus_lines_oe_o &&
        direction_ctl_out_o && target_bus_lines_o == addr_ff[7:0] &&
        port_two_low_pins_o == addr_ff[9:8])
        else $error("wrong address at latch pulse");
    AST_DATA: assert property (!pulse_drive_n_o |-> target_bus_lines_oe_o &&
        target_bus_lines_o == wdata_ff)
        else $error("wrong word during program pulse");
    AST_HV: assert property (!pulse_drive_n_o |-> !supply_boost_n_o &&
        !high_addr_drive_n_o && !direction_ctl_out_o)
        else $error("program pulse without high levels");
    AST_GROUND: assert property ($fell(pulse_drive_n_o) |->
        $past(write_pulse_ground_o) && !write_pulse_ground_o)
        else $error("pulse pin not grounded before drive");
    AST_PULSE_LEN: assert property (s_pulse_end |->
        pcnt_ff >= PULSE_CYC && pcnt_ff <= PULSE_CYC + 1)
        else $error("program pulse length wrong");
    AST_BOOST: assert property (!supply_boost_n_o |-> supply_fall_ctl_n_o)
        else $error("boost while fall control active");
    AST_FALL: assert property (s_pulse_end |-> !supply_fall_ctl_n_o && supply_boost_n_o)
        else $error("supply not pulled back after program pulse");
    AST_XTAL: assert property (xcnt_ff < 10)
        else $error("crystal reference stopped");
endmodule
bind ewp_programmer ewp_programmer_chk #(.PULSE_CYC(PULSE_CYC)) chk_u (
    .clock_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
    .target_bus_lines_o, .target_bus_lines_oe_o, .port_two_low_pins_o,
    .target_reset_pulse_o, .direction_ctl_out_o, .high_addr_drive_n_o, .supply_boost_n_o,
    .supply_fall_ctl_n_o, .pulse_drive_n_o, .write_pulse_ground_o, .crystal_input_pin_o);
`default_nettype wire

// >>> ewp_target_model.sv
`timescale 1ns/100ps
`default_nettype none
module ewp_target_model #(
    parameter integer FETCHES = 8
) (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic       present_i,
    input  wire logic [7:0] stuck_i,
    input  wire logic [7:0] bus_in_i,
    input  wire logic       bus_oe_i,
    input  wire logic       dir_i,
    input  wire logic [1:0] p2_i,
    input  wire logic       reset_pulse_i,
    input  wire logic       boost_n_i,
    input  wire logic       mode_n_i,
    input  wire logic       pulse_n_i,
    output logic [7:0]      bus_out_o,
    output logic            strobe_o
);
    logic [7:0] mem_ff [0:1023];
    logic [9:0] addr_ff;
    logic       rp_ff;
    logic [7:0] junk_ff;
    integer     fcnt_ff;
    // Erased words read as zero.
    initial for (int i = 0; i < 1024; i++) mem_ff[i] = 8'h00;
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rp_ff <= 1'b1;
            junk_ff <= 8'h5A;
            fcnt_ff <= 0;
            strobe_o <= 1'b0;
            addr_ff <= 10'h000;
        end else begin
            rp_ff <= reset_pulse_i;
            junk_ff <= ~junk_ff;
            if (!rp_ff && reset_pulse_i) begin
                if (bus_oe_i) addr_ff <= {p2_i, bus_in_i};
                fcnt_ff <= present_i ? 2 * FETCHES : 0;
            end else if (fcnt_ff > 0) begin
                fcnt_ff <= fcnt_ff - 1;
                strobe_o <= ~strobe_o;
            end
            // Stuck bits model a worn cell, so only ones not stuck can be added.
            if (!pulse_n_i && !boost_n_i && !mode_n_i && bus_oe_i)
                mem_ff[addr_ff] <= mem_ff[addr_ff] | (bus_in_i & ~stuck_i);
        end
    end
    // Outside a read the lines carry a changing pattern, never the last byte.
    assign bus_out_o = (dir_i && !bus_oe_i) ? ~mem_ff[addr_ff] : junk_ff;
endmodule
`default_nettype wire

// >>> tb_eprom_word_programmer.sv
`timescale 1ns/100ps
`default_nettype none
`include "ewp_defines.vh"
module tb_eprom_word_programmer;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic        high_voltage_ok_i = 1'b1;
    logic        present = 1'b1;
    logic [7:0]  stuck = 8'h00;
    wire  [31:0] prdata_o;
    wire  [7:0]  target_bus_lines_i, target_bus_lines_o, read_word_o;
    wire  [1:0]  port_two_low_pins_o;
    wire         pready_o, pslverr_o, target_bus_lines_oe_o, fetch_strobe_i;
    wire         target_reset_pulse_o, direction_ctl_out_o, high_addr_drive_n_o;
    wire         supply_boost_n_o, supply_fall_ctl_n_o, pulse_drive_n_o;
    wire         write_pulse_ground_o, crystal_input_pin_o;
    integer      failures = 0;
    integer      comparisons = 0;
    integer      cyc = 0;
    integer      seed = 32'h3EA6;
    integer      k;
    logic [31:0] q;
    logic        e;
    logic [11:0] ra;
    logic [7:0]  mem [0:1023];
    always #5 clock_i = ~clock_i;
    ewp_programmer #(.PULSE_CYC(50), .STEP_CYC(4), .SCAN_CYC(200), .FETCHES(8)) dut_u (
        .clock_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .target_bus_lines_i, .target_bus_lines_o,
        .target_bus_lines_oe_o, .port_two_low_pins_o, .fetch_strobe_i, .high_voltage_ok_i,
        .target_reset_pulse_o, .direction_ctl_out_o, .high_addr_drive_n_o,
        .supply_boost_n_o, .supply_fall_ctl_n_o, .pulse_drive_n_o, .write_pulse_ground_o,
        .crystal_input_pin_o, .read_word_o);
    ewp_target_model #(.FETCHES(8)) tgt_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .present_i(present), .stuck_i(stuck), .bus_in_i(target_bus_lines_o),
        .bus_oe_i(target_bus_lines_oe_o), .dir_i(direction_ctl_out_o),
        .p2_i(port_two_low_pins_o), .reset_pulse_i(target_reset_pulse_o),
        .boost_n_i(supply_boost_n_o), .mode_n_i(high_addr_drive_n_o),
        .pulse_n_i(pulse_drive_n_o), .bus_out_o(target_bus_lines_i), .strobe_o(fetch_strobe_i));
    task give_verdict;
        begin
            $display("comparisons %0d failures %0d", comparisons, failures);
            if (failures == 0 && comparisons > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("unexpected %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task apb(input logic wr, input logic [11:0] ta, input logic [31:0] td,
             output logic [31:0] tq, output logic te);
        begin
            psel_i <= 1'b1;
            penable_i <= 1'b0;
            pwrite_i <= wr;
            paddr_i <= ta;
            pwdata_i <= td;
            @(posedge clock_i);
            penable_i <= 1'b1;
            @(posedge clock_i);
            while (pready_o !== 1'b1) begin
                @(posedge clock_i);
            end
            tq = prdata_o;
            te = pslverr_o;
            psel_i <= 1'b0;
            penable_i <= 1'b0;
            @(posedge clock_i);
        end
    endtask
    task set_env(input logic p, input logic h, input logic [7:0] s);
        begin
            present <= p;
            high_voltage_ok_i <= h;
            stuck <= s;
            @(posedge clock_i);
        end
    endtask
    task op(input logic write_pulse_pin, input logic [11:0] ta, input logic [7:0] td);
        logic [7:0] m;
        logic       rn, ins, nohv, verr, ok, rd;
        integer     n;
        begin
            apb(1'b1, `EWP_REG_ADDR, {20'h0, ta}, q, e);
            apb(1'b1, `EWP_REG_WDATA, {24'h0, td}, q, e);
            apb(1'b1, `EWP_REG_CTRL, write_pulse_pin ? 32'h1 : 32'h2, q, e);
            n = 0;
            q = 32'h0;
            while (q[`EWP_ST_DONE] !== 1'b1 && n < 500) begin
                apb(1'b0, `EWP_REG_STATUS, 32'h0, q, e);
                n = n + 1;
            end
            rn = !(ta[11] | ta[10]);
            ins = !present;
            nohv = write_pulse_pin && !high_voltage_ok_i && rn && !ins;
            verr = 1'b0;
            m = mem[ta[9:0]];
            if (rn && !ins && !nohv && write_pulse_pin) begin
                m = m | (td & ~stuck);
                verr = (m !== td);
                mem[ta[9:0]] = m;
            end
            ok = rn && !ins && !nohv && !verr;
            rd = rn && !ins && !nohv;
            check("status", {24'h0, q[7:0]},
                  {24'h0, rd, verr, nohv, ins, rn, ok, 2'b10});
            if (rd) begin
                apb(1'b0, `EWP_REG_RDATA, 32'h0, q, e);
                check("rdata", {24'h0, q[7:0]}, {24'h0, m});
                check("read_word", {24'h0, read_word_o}, {24'h0, m});
            end
        end
    endtask
    // A hang in any wait ends the run as a failure.
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures = failures + 1;
            give_verdict;
        end
    end
    initial begin
        for (k = 0; k < 1024; k = k + 1) mem[k] = 8'h00;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        apb(1'b0, 12'h020, 32'h0, q, e);
        check("unmapped error", {31'h0, e}, 32'h1);
        check("unmapped data", q, 32'h0);
        op(1'b0, 12'h005, 8'h00);
        for (k = 0; k < 4; k = k + 1) begin
            ra = {2'b00, 10'($random(seed))};
            op(1'b1, ra, 8'($random(seed)));
            op(1'b0, ra, 8'h00);
        end
        op(1'b1, 12'h2A0, 8'hF0);
        op(1'b1, 12'h2A0, 8'h0F);
        op(1'b1, 12'h400, 8'hAA);
        op(1'b0, 12'h800, 8'h00);
        set_env(1'b0, 1'b1, 8'h00);
        op(1'b0, 12'h010, 8'h00);
        op(1'b1, 12'h011, 8'h11);
        set_env(1'b1, 1'b0, 8'h00);
        op(1'b1, 12'h012, 8'h12);
        set_env(1'b1, 1'b1, 8'h81);
        op(1'b1, 12'h3FF, 8'hFF);
        set_env(1'b1, 1'b1, 8'h00);
        op(1'b0, 12'h3FF, 8'h00);
        give_verdict;
    end
endmodule
`default_nettype wire
